// file: verilog/aer_top.sv
// Behaviour
// - request rises when run command turns on
// - request high starts absolute data reception
// - wait 100 ms, then await serial data
// - receive exactly eight characters, then finish
// - incremental counting about 50 ms after last
// - serial 9600 baud, 7E1 ASCII on phase A
// - position counts wrap modulo 2**POS_W
// - encoder position = revolutions*pulses + initial
// - present value = encoder position - setup pulses
// - origin command rising edge starts origin set
// - origin clears present, stores absolute setting
// - after origin set, save parameters to flash
// - origin accepted even with servo unlocked
// - stored settings readable, never writable by reads
`include "aer_map.svh"

module aer_top
   import aer_pkg::*;
#(
   parameter int POS_W      = 32,
   parameter int PPR_W      = 16,
   parameter int WAIT_CYC   = `AER_WAIT_MS * (`AER_CLK_HZ / 1000),
   parameter int SETTLE_CYC = `AER_SETTLE_MS * (`AER_CLK_HZ / 1000),
   parameter int BIT_CYC    = `AER_CLK_HZ / `AER_BAUD
) (
   input  wire logic             core_clk,
   input  wire logic             reset,
   input  wire logic             run_command,
   input  wire logic             phase_a,
   input  wire logic             phase_b,
   input  wire logic             origin_command,
   input  wire logic [PPR_W-1:0] pulses_per_rev,
   input  wire logic             unit_read_instruction,
   output logic                  absolute_data_request,
   output logic                  incremental_mode,
   output logic                  absolute_error,
   output logic signed [17:0]    revolution_count,
   output logic [POS_W-1:0]      encoder_position,
   output logic [POS_W-1:0]      present_value,
   output logic                  flash_save_request,
   output logic [POS_W-1:0]      read_data,
   output logic                  read_valid
);
   initial begin
      // position wraps modulo 2**POS_W, like the pulse counter itself
      if (POS_W < 18 || POS_W <= PPR_W || WAIT_CYC < 1 || SETTLE_CYC < 1 || BIT_CYC < 4)
         $error("aer_top: parameters out of range");
   end

   // ==========================================================
   // pin synchronisers
   logic a_meta, a_sync, a_prev;
   logic b_meta, b_sync, b_prev;

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         a_meta <= 1'b1;
         a_sync <= 1'b1;
         a_prev <= 1'b1;
         b_meta <= 1'b1;
         b_sync <= 1'b1;
         b_prev <= 1'b1;
      end else begin
         a_meta <= phase_a;
         a_sync <= a_meta;
         a_prev <= a_sync;
         b_meta <= phase_b;
         b_sync <= b_meta;
         b_prev <= b_sync;
      end
   end

   // ==========================================================
   // serial receiver on phase A
   logic        rx_busy;
   logic [31:0] rx_timer;
   logic [3:0]  rx_idx;
   logic [6:0]  rx_shift;
   logic        rx_par;
   logic        rx_bad;
   logic        rx_push;
   aer_char_t   rx_word;
   logic        buf_in_ready;
   logic        rx_overrun;
   logic        rx_listen;
   aer_state_e  state;

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         rx_busy  <= 1'b0;
         rx_timer <= '0;
         rx_idx   <= '0;
         rx_shift <= '0;
         rx_par   <= 1'b0;
         rx_bad   <= 1'b0;
         rx_push  <= 1'b0;
         rx_word  <= '0;
      end else begin
         rx_push <= 1'b0;
         if (!rx_listen) begin
            rx_busy <= 1'b0;                  // quadrature on phase a is no frame
         end else if (!rx_busy) begin
            if (a_prev && !a_sync) begin
               rx_busy  <= 1'b1;
               rx_timer <= 32'(BIT_CYC / 2);
               rx_idx   <= '0;
               rx_par   <= 1'b0;
               rx_bad   <= 1'b0;
            end
         end else if (rx_timer != '0) begin
            rx_timer <= rx_timer - 32'd1;
         end else begin
            rx_timer <= 32'(BIT_CYC - 1);
            rx_idx   <= rx_idx + 4'd1;
            if (rx_idx == 4'd0) begin
               if (a_sync)
                  rx_busy <= 1'b0;            // glitch, not a start bit
            end else if (rx_idx < 4'(`AER_PARITY_IDX)) begin
               rx_shift <= {a_sync, rx_shift[6:1]};
               rx_par   <= rx_par ^ a_sync;
            end else if (rx_idx == 4'(`AER_PARITY_IDX)) begin
               rx_bad <= rx_par ^ a_sync;              // even parity
            end else begin
               rx_busy <= 1'b0;
               rx_push <= 1'b1;
               rx_word <= {rx_bad | !a_sync, rx_shift}; // framing
            end
         end
      end
   end

   assign rx_overrun = rx_push && !buf_in_ready;
   // listen only around a request, so counting edges never leave it mid-frame
   assign rx_listen  = (state == AER_WAIT) || (state == AER_RECV);

   // ==========================================================
   // character buffer
   aer_char_t ch_word;
   logic      ch_valid;
   logic      ch_ready;
   logic      ch_take;

   aer_buffer #(
      .WIDTH ($bits(aer_char_t)),
      .DEPTH (2)
   ) u_buffer (
      .core_clk  (core_clk),
      .reset     (reset),
      .in_data   (rx_word),
      .in_valid  (rx_push),
      .in_ready  (buf_in_ready),
      .out_data  (ch_word),
      .out_valid (ch_valid),
      .out_ready (ch_ready)
   );

   // ==========================================================
   // sequencer
   aer_state_e  next_state;
   logic [31:0] seq_cnt;
   logic        run_prev;
   logic [2:0]  ch_idx;
   logic        last_char;
   logic        calc_pending;

   // parser stalls one cycle while the product is loaded
   assign ch_ready  = !calc_pending;
   assign ch_take   = ch_valid && ch_ready;
   assign last_char = ch_take && state == AER_RECV && ch_idx == 3'(`AER_MSG_CHARS - 1);

   always_comb begin
      next_state = state;
      unique case (state)
         AER_IDLE:
            if (run_command && !run_prev)
               next_state = AER_WAIT;
         AER_WAIT:
            if (seq_cnt == 32'(WAIT_CYC - 1))
               next_state = AER_RECV;
         AER_RECV:
            if (last_char)
               next_state = AER_SETTLE;
         AER_SETTLE:
            if (seq_cnt == 32'(SETTLE_CYC - 1))
               next_state = AER_INCR;
         AER_INCR:
            next_state = AER_INCR;
      endcase
      if (!run_command)
         next_state = AER_IDLE;
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         state    <= AER_IDLE;
         seq_cnt  <= '0;
         run_prev <= 1'b0;
      end else begin
         state    <= next_state;
         run_prev <= run_command;
         seq_cnt  <= (next_state != state) ? '0 : seq_cnt + 32'd1;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         absolute_data_request <= 1'b0;
         incremental_mode      <= 1'b0;
      end else begin
         absolute_data_request <= (next_state != AER_IDLE);
         incremental_mode      <= (next_state == AER_INCR);
      end
   end

   // ==========================================================
   // message parser
   logic [16:0] rev_mag;
   logic        rev_neg;
   logic        fmt_bad;

   function automatic logic is_digit(input logic [6:0] c);
      return c >= `AER_CH_ZERO && c <= `AER_CH_NINE;
   endfunction

   always_comb begin
      fmt_bad = 1'b0;
      if (ch_take && state == AER_RECV) begin
         unique case (ch_idx)
            3'd0: fmt_bad = ch_word[6:0] != `AER_CH_P && ch_word[6:0] != `AER_CH_A;
            3'd1: fmt_bad = ch_word[6:0] != `AER_CH_PLUS && ch_word[6:0] != `AER_CH_MINUS;
            3'd7: fmt_bad = ch_word[6:0] != `AER_CH_CR;
            default: fmt_bad = !is_digit(ch_word[6:0]);
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         ch_idx  <= '0;
         rev_mag <= '0;
         rev_neg <= 1'b0;
      end else if (state != AER_RECV) begin
         ch_idx  <= '0;
         rev_mag <= '0;
      end else if (ch_take) begin
         ch_idx <= ch_idx + 3'd1;
         if (ch_idx == 3'd1)
            rev_neg <= ch_word[6:0] == `AER_CH_MINUS;  // 00000 is still zero
         else if (ch_idx >= 3'd2 && ch_idx <= 3'd6)
            rev_mag <= 17'((rev_mag << 3) + (rev_mag << 1)
                       + 17'(ch_word[3:0]));           // decimal digits
      end
   end

   // ==========================================================
   // error flag: a new fault wins over the clear at a new request
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset)
         absolute_error <= 1'b0;
      else if (fmt_bad || rx_overrun
               || (ch_take && state == AER_RECV && ch_word[7]))
         absolute_error <= 1'b1;
      else if (state == AER_IDLE && next_state == AER_WAIT)
         absolute_error <= 1'b0;
   end

   // ==========================================================
   // position arithmetic
   logic [POS_W-1:0] setup_offset;
   logic [1:0]       quad_now;
   logic [1:0]       quad_old;
   logic [POS_W-1:0] quad_step;
   logic signed [POS_W-1:0] rev_product;
   logic signed [POS_W-1:0] ppr_wide;
   logic signed [POS_W-1:0] rev_wide;

   assign quad_now = {a_sync, b_sync};
   assign quad_old = {a_prev, b_prev};

   // x4 decoding; an illegal double jump is ignored
   always_comb begin
      quad_step = '0;
      unique case ({quad_old, quad_now})
         4'b0010, 4'b1011, 4'b1101, 4'b0100: quad_step = POS_W'(1);
         4'b0001, 4'b0111, 4'b1110, 4'b1000: quad_step = '1;
         default: quad_step = '0;
      endcase
   end

   // widen first: a product sized by its operands would lose the high part
   assign ppr_wide    = POS_W'(pulses_per_rev);
   assign rev_wide    = POS_W'(revolution_count);
   assign rev_product = ppr_wide * rev_wide;

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         revolution_count <= '0;
         calc_pending     <= 1'b0;
      end else begin
         calc_pending <= last_char;
         if (last_char)
            revolution_count <= rev_neg ? -$signed({1'b0, rev_mag})
                                        : $signed({1'b0, rev_mag});
      end
   end

   // initial pulses land during the settle window, so they add onto M*R
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset)
         encoder_position <= `AER_POS_RESET;
      else if (calc_pending)
         encoder_position <= POS_W'(rev_product) + quad_step;
      else if (state == AER_SETTLE || state == AER_INCR)
         encoder_position <= encoder_position + quad_step;
   end

   // ==========================================================
   // absolute origin setting
   logic origin_prev;
   logic origin_edge;

   // taken in any servo state; this block has no lock gating
   assign origin_edge = origin_command && !origin_prev;

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         origin_prev        <= 1'b0;
         setup_offset       <= `AER_POS_RESET;
         flash_save_request <= 1'b0;
      end else begin
         origin_prev        <= origin_command;
         flash_save_request <= origin_edge;
         if (origin_edge)
            setup_offset <= encoder_position;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset)
         present_value <= `AER_POS_RESET;
      else if (origin_edge)
         present_value <= '0;
      else
         present_value <= encoder_position - setup_offset;
   end

   // ==========================================================
   // read-only view of the stored setting
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         read_data  <= `AER_POS_RESET;
         read_valid <= 1'b0;
      end else begin
         read_valid <= unit_read_instruction;
         if (unit_read_instruction)
            read_data <= setup_offset;
      end
   end
endmodule

// file: pkg/aer_map.svh
`ifndef AER_MAP_SVH
`define AER_MAP_SVH
// ==========================================================
// clock and link timing
`define AER_CLK_HZ      40000000
`define AER_BAUD        9600
`define AER_WAIT_MS     100
`define AER_SETTLE_MS   50
// ==========================================================
// serial frame: start, 7 data, parity, stop
`define AER_DATA_BITS   7
`define AER_FRAME_BITS  10
`define AER_PARITY_IDX  8
`define AER_STOP_IDX    9
`define AER_MSG_CHARS   8
// ==========================================================
// message characters
`define AER_CH_P        7'h50
`define AER_CH_A        7'h41
`define AER_CH_PLUS     7'h2B
`define AER_CH_MINUS    7'h2D
`define AER_CH_ZERO     7'h30
`define AER_CH_NINE     7'h39
`define AER_CH_CR       7'h0D
// ==========================================================
// reset values
`define AER_POS_RESET   32'h0000_0000
`endif

// file: pkg/aer_pkg.sv
package aer_pkg;
   // ==========================================================
   // readout sequencer
   typedef enum logic [2:0] {
      AER_IDLE,
      AER_WAIT,
      AER_RECV,
      AER_SETTLE,
      AER_INCR
   } aer_state_e;

   // received character with its error mark in bit 7
   typedef logic [7:0] aer_char_t;
endpackage

// file: verilog/aer_buffer.sv
module aer_buffer #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   input  wire logic             core_clk,
   input  wire logic             reset,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   initial begin
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
         $error("aer_buffer: DEPTH must be a power of two, at least 2");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;

   assign push = in_valid && in_ready;
   assign pop  = out_valid && out_ready;

   // ==========================================================
   // storage and pointers
   always_ff @(posedge core_clk) begin
      if (push)
         mem[wr_ptr] <= in_data;
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push)
            wr_ptr <= wr_ptr + AW'(1);
         if (pop)
            rd_ptr <= rd_ptr + AW'(1);
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   // ==========================================================
   // flags; ready drops only when truly full
   assign in_ready  = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data  = mem[rd_ptr];
endmodule

// file: test/aer_encoder_model.sv
module aer_encoder_model #(
   parameter int BIT_CYC = 16
) (
   input  wire logic core_clk,
   output logic      phase_a,
   output logic      phase_b
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // serial line rests high between frames
   initial begin
      phase_a = 1'b1;
      phase_b = 1'b0;
   end
   task automatic put_bit(input logic b);
      phase_a <= b;
      repeat (BIT_CYC) @(posedge core_clk);
   endtask
   // ==========================================================
   // message: start, 7 bits lsb first, even parity, stop
   // bad_ch 0..7 spoils that character's parity, 8..15 the stop bit of char bad_ch-8
   task automatic send_msg(input logic [55:0] msg, input int bad_ch);
      logic [6:0] c;
      for (int i = 0; i < 8; i++) begin
         c = msg[55-7*i -: 7];
         put_bit(1'b0);
         for (int j = 0; j < 7; j++) begin
            put_bit(c[j]);
         end
         put_bit(^c ^ (i == bad_ch));
         put_bit(i + 8 != bad_ch);
      end
      // a spoilt stop bit leaves the line low; return it to idle
      if (bad_ch > 7) begin
         put_bit(1'b1);
      end
   endtask
   // initial pulses, a leads b; multiples of four leave phase a high
   task automatic step(input int n);
      for (int i = 0; i < n; i++) begin
         {phase_a, phase_b} <= {~phase_b, phase_a};
         repeat (3) @(posedge core_clk);
      end
   endtask
endmodule

// file: test/aer_top_sva.sv
module aer_top_sva #(
   parameter int POS_W      = 32,
   parameter int WAIT_CYC   = 50,
   parameter int SETTLE_CYC = 40
) (
   input wire logic             core_clk,
   input wire logic             reset,
   input wire logic             run_command,
   input wire logic             origin_command,
   input wire logic             unit_read_instruction,
   input wire logic             absolute_data_request,
   input wire logic             incremental_mode,
   input wire logic             absolute_error,
   input wire logic [POS_W-1:0] encoder_position,
   input wire logic [POS_W-1:0] present_value,
   input wire logic             flash_save_request,
   input wire logic [POS_W-1:0] read_data,
   input wire logic             read_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   int               age;
   logic [POS_W-1:0] off;
   // ==========================================================
   // helpers: time with request up, offset caught at origin
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         age <= 0;
      end else if (!absolute_data_request) begin
         age <= 0;
      end else if (age < 1000000) begin
         age <= age + 1;
      end
   end
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         off <= '0;
      end else if ($rose(origin_command)) begin
         off <= encoder_position;
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   // ==========================================================
   // properties
   property p_req_rise; $rose(run_command) |=> absolute_data_request; endproperty
   property p_req_drop; $fell(run_command) |=> !absolute_data_request; endproperty
   property p_wait; $rose(incremental_mode) |-> age >= WAIT_CYC + SETTLE_CYC; endproperty
   property p_err_clr; $rose(absolute_data_request) |-> ##[0:1] !absolute_error; endproperty
   property p_org; $rose(origin_command) |=> flash_save_request && present_value == '0;
   endproperty
   property p_flash; flash_save_request |-> $past(origin_command) && !$past(origin_command, 2);
   endproperty
   property p_pv; !flash_save_request |-> present_value == $past(encoder_position) - off;
   endproperty
   property p_rd; unit_read_instruction |=> read_valid && read_data == off; endproperty
   property p_rd_only; read_valid |-> $past(unit_read_instruction); endproperty
   a_req_rise: assert property (p_req_rise) else $error("request not raised");
   a_req_drop: assert property (p_req_drop) else $error("request not dropped");
   a_wait: assert property (p_wait) else $error("incremental mode too early");
   a_err_clr: assert property (p_err_clr) else $error("error not cleared");
   a_org: assert property (p_org) else $error("origin not taken");
   a_flash: assert property (p_flash) else $error("stray flash save");
   a_pv: assert property (p_pv) else $error("present value wrong");
   a_rd: assert property (p_rd) else $error("read answer wrong");
   a_rd_only: assert property (p_rd_only) else $error("stray read valid");
   c_incr: cover property ($rose(incremental_mode));
   c_org: cover property (flash_save_request);
   c_err: cover property ($rose(absolute_error));
endmodule

bind aer_top aer_top_sva #(
   .POS_W(POS_W), .WAIT_CYC(WAIT_CYC), .SETTLE_CYC(SETTLE_CYC)
) u_sva (
   .core_clk(core_clk), .reset(reset), .run_command(run_command),
   .origin_command(origin_command), .unit_read_instruction(unit_read_instruction),
   .absolute_data_request(absolute_data_request), .incremental_mode(incremental_mode),
   .absolute_error(absolute_error), .encoder_position(encoder_position),
   .present_value(present_value), .flash_save_request(flash_save_request),
   .read_data(read_data), .read_valid(read_valid)
);

// file: test/aer_top_tb.sv
module aer_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int WAIT_CYC   = 50;
   localparam int SETTLE_CYC = 80;
   localparam int BIT_CYC    = 16;
   logic               core_clk = 1'b0;
   logic               reset, run_command, origin_command, unit_read_instruction;
   logic               phase_a, phase_b, absolute_data_request, incremental_mode;
   logic               absolute_error, flash_save_request, read_valid;
   logic [15:0]        pulses_per_rev;
   logic signed [17:0] revolution_count;
   logic [31:0]        encoder_position, present_value, read_data;
   int                 fails, num_checks, i;
   always #12.5 core_clk = ~core_clk;
   aer_top #(.WAIT_CYC(WAIT_CYC), .SETTLE_CYC(SETTLE_CYC), .BIT_CYC(BIT_CYC)) uut (
      .core_clk(core_clk), .reset(reset), .run_command(run_command),
      .phase_a(phase_a), .phase_b(phase_b), .origin_command(origin_command),
      .pulses_per_rev(pulses_per_rev), .unit_read_instruction(unit_read_instruction),
      .absolute_data_request(absolute_data_request), .incremental_mode(incremental_mode),
      .absolute_error(absolute_error), .revolution_count(revolution_count),
      .encoder_position(encoder_position), .present_value(present_value),
      .flash_save_request(flash_save_request), .read_data(read_data),
      .read_valid(read_valid)
   );
   aer_encoder_model #(.BIT_CYC(BIT_CYC)) u_enc (
      .core_clk(core_clk), .phase_a(phase_a), .phase_b(phase_b)
   );
   // ==========================================================
   // shared tasks
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wrap_up;
      $display("checks=%0d fails=%0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   function automatic logic [55:0] mk(input logic [6:0] lead, sgn, input int n);
      logic [55:0] m;
      int          d;
      m = {lead, sgn, 35'h0, 7'h0D};
      d = 10000;
      for (int k = 0; k < 5; k++) begin
         m[41-7*k -: 7] = 7'(7'h30 + (n / d) % 10);
         d = d / 10;
      end
      return m;
   endfunction
   // ==========================================================
   // scenarios
   task automatic readout(input logic [6:0] lead, sgn, input int n, bad, edges, r,
                          input logic err);
      int m;
      m = (sgn == 7'h2D) ? -n : n;
      @(posedge core_clk);
      pulses_per_rev <= r[15:0];
      run_command    <= 1'b0;
      repeat (2) @(posedge core_clk);
      run_command <= 1'b1;
      @(negedge core_clk);
      check(absolute_data_request, 0);
      @(negedge core_clk);
      check(absolute_data_request, 1);
      @(negedge core_clk);
      check(absolute_error, 0);
      repeat (WAIT_CYC + 10) @(posedge core_clk);
      check(incremental_mode, 0);
      u_enc.send_msg(mk(lead, sgn, n), bad);
      u_enc.step(edges);
      for (i = 0; i < 400 && incremental_mode !== 1'b1 && absolute_error !== 1'b1; i++)
         @(negedge core_clk);
      if (i == 400) begin
         fails++;
         wrap_up();
      end
      check(absolute_error, err);
      if (!err) begin
         check(32'(revolution_count), 32'(m));
         check(encoder_position, 32'(m * r + edges));
         check(incremental_mode, 1);
      end
   endtask
   task automatic origin;
      @(posedge core_clk);
      origin_command <= 1'b1;
      @(posedge core_clk);
      origin_command <= 1'b0;
      @(negedge core_clk);
      check(flash_save_request, 1);
      check(present_value, 0);
      @(negedge core_clk);
      check(flash_save_request, 0);
   endtask
   task automatic read_back(input logic [31:0] exp);
      @(posedge core_clk);
      unit_read_instruction <= 1'b1;
      @(posedge core_clk);
      unit_read_instruction <= 1'b0;
      @(negedge core_clk);
      check(read_valid, 1);
      check(read_data, exp);
      @(negedge core_clk);
      check(read_valid, 0);
   endtask
   // ==========================================================
   // main sequence and watchdog
   initial begin
      reset = 1'b1;
      run_command = 1'b0;
      origin_command = 1'b0;
      unit_read_instruction = 1'b0;
      pulses_per_rev = 16'h0064;
      repeat (3) @(posedge core_clk);
      reset <= 1'b0;
      repeat (2) @(posedge core_clk);
      readout(7'h50, 7'h2B, 12, -1, 8, 100, 1'b0);
      origin(); // no power-up or download in progress
      read_back(32'd1208);
      u_enc.step(4);
      for (i = 0; i < 20 && present_value !== 32'd4; i++)
         @(negedge core_clk);
      check(present_value, 32'd4);
      check(encoder_position, 32'd1212);
      @(posedge core_clk);
      run_command <= 1'b0;
      @(negedge core_clk);
      @(negedge core_clk);
      check(absolute_data_request, 0);
      origin();
      readout(7'h41, 7'h2D, 0, -1, 4, 100, 1'b0);
      readout(7'h50, 7'h2D, 99999, -1, 12, 250, 1'b0);
      readout(7'h50, 7'h2B, 1, 3, 0, 100, 1'b1);
      readout(7'h58, 7'h2B, 1, -1, 0, 100, 1'b1);
      readout(7'h50, 7'h2B, 1, 15, 0, 100, 1'b1);
      readout(7'h50, 7'h2B, 2, -1, 4, 100, 1'b0);
      wrap_up();
   end
   initial begin
      repeat (100000) @(posedge core_clk);
      fails++;
      wrap_up();
   end
endmodule
